// file: core/sjx_pkg.sv
// Package: encodings and widths for the skip and jump execution block
package sjx_pkg;
    localparam int          SJX_IW          = 14;
    localparam int          SJX_PCW         = 13;
    localparam logic [5:0]  SJX_OP_DECSKIP  = 6'h0b;
    localparam logic [5:0]  SJX_OP_INCSKIP  = 6'h0f;
    localparam logic [1:0]  SJX_OP_JUMP     = 2'h2;
    localparam int          SJX_DEST_BIT    = 7;
    localparam int          SJX_OPH_LSB     = 8;
    localparam int          SJX_LIT_MSB     = 10;
    localparam int          SJX_LATCH_HI    = 4;
    localparam int          SJX_LATCH_LO    = 3;
    localparam logic [12:0] SJX_PC_RESET    = 13'h0000;
    localparam logic [7:0]  SJX_ONE         = 8'h01;
    localparam logic [7:0]  SJX_ZERO        = 8'h00;

    // Operation classes produced by the decoder
    typedef enum logic [1:0] {
        SJX_K_OTHER = 2'h0,
        SJX_K_DEC   = 2'h1,
        SJX_K_INC   = 2'h3,
        SJX_K_JUMP  = 2'h2
    } sjx_kind_t;

    // Execution slot state: normal run or bubble after a flush
    typedef enum logic {
        SJX_S_RUN    = 1'b0,
        SJX_S_BUBBLE = 1'b1
    } sjx_state_t;
endpackage : sjx_pkg

// file: core/sjx_decode.sv
// Decoder: classifies one instruction word into skip, jump or other
module sjx_decode
    import sjx_pkg::*;
(
    // Instruction word
    input  wire logic [SJX_IW-1:0] instr,
    // Decoded class and fields
    output sjx_kind_t              kind,
    output logic                   dest_reg,
    output logic [6:0]             reg_addr,
    output logic [10:0]            literal
);
    // Opcode match; everything not matched is left to the rest of the core
    always_comb begin
        kind = SJX_K_OTHER;
        if (instr[13:SJX_OPH_LSB] == SJX_OP_DECSKIP) begin
            kind = SJX_K_DEC;
        end else if (instr[13:SJX_OPH_LSB] == SJX_OP_INCSKIP) begin
            kind = SJX_K_INC;
        end else if (instr[13:12] == SJX_OP_JUMP) begin
            kind = SJX_K_JUMP;
        end
    end

    // Field extraction
    assign dest_reg = instr[SJX_DEST_BIT];
    assign reg_addr = instr[6:0];
    assign literal  = instr[SJX_LIT_MSB:0];
endmodule : sjx_decode

// file: core/sjx_exec.sv
// Execution slot for decrement/increment-skip-on-zero and absolute jump
// Contract
// - Decrement-skip is opcode 00 1011, then target flag and 7-bit register address.
// - Decrement-skip subtracts one and skips the next instruction on zero result.
// - Increment-skip is opcode 00 1111, then target flag and 7-bit register address.
// - Increment-skip adds one and skips the next instruction when result wraps to zero.
// - Target flag 0 writes the accumulator, flag 1 writes the register back.
// - A taken skip discards the prefetched instruction without any effect.
// - Skip takes one cycle, or two with a no-op when taken.
// - Jump, top bits 10, loads its 11-bit literal into counter bits 10 to 0.
// - Jump fills counter bits 12 and 11 from latch bits 4 and 3.
// - Jump always takes two cycles, flushing the prefetched instruction.
module sjx_exec
    import sjx_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // Prefetch stage: word fetched in the previous cycle, now executing
    input  wire logic [SJX_IW-1:0]  instr,
    input  wire logic               instr_valid,
    // Register file and latch
    input  wire logic [7:0]         reg_rdata,
    input  wire logic [7:0]         pc_high_latch,
    // Execution results
    output logic [6:0]              reg_raddr,
    output logic                    reg_we,
    output logic [6:0]              reg_waddr,
    output logic [7:0]              reg_wdata,
    output logic                    acc_we,
    output logic [7:0]              acc_wdata,
    output logic                    status_we,
    // Program counter and prefetch control
    output logic [SJX_PCW-1:0]      pc,
    output logic                    flush,
    output logic                    bubble,
    output logic                    other_exec
);
    sjx_kind_t  kind;
    logic       dest_reg;
    logic [6:0] reg_addr;
    logic [10:0] literal;
    logic [7:0] result;
    logic       zero;
    logic       live;

    // All state of the slot
    // Data outputs come straight from these flops, never from the decoder
    typedef struct packed {
        sjx_state_t       st;
        logic [SJX_PCW-1:0] pc;
        logic             reg_we;
        logic [6:0]       reg_waddr;
        logic [7:0]       reg_wdata;
        logic             acc_we;
        logic [7:0]       acc_wdata;
    } sjx_reg_t;

    sjx_reg_t r;
    sjx_reg_t next_r;

    sjx_decode u_dec (
        .instr    (instr),
        .kind     (kind),
        .dest_reg (dest_reg),
        .reg_addr (reg_addr),
        .literal  (literal)
    );

    // Skip class test; shared by the flush term and the checks
    function automatic logic sjx_is_skip(input sjx_kind_t k);
        return (k == SJX_K_DEC) || (k == SJX_K_INC);
    endfunction : sjx_is_skip

    // Arithmetic on the operand read combinationally this cycle
    // Eight-bit wrap is wanted: 8'h00 minus one and 8'hff plus one both wrap
    always_comb begin
        result = SJX_ZERO;
        if (kind == SJX_K_DEC) begin
            result = reg_rdata - SJX_ONE;
        end else if (kind == SJX_K_INC) begin
            result = reg_rdata + SJX_ONE;
        end
    end

    assign zero = (result == SJX_ZERO);
    // The bubble slot executes nothing, whatever the prefetch holds
    // A word arriving in the dead slot is dropped, yet still moves the counter on
    assign live = instr_valid && (r.st == SJX_S_RUN);

    // Next-state logic for counter, destination writes and bubble
    // Write strobes default low, so each result pulses for exactly one cycle
    // Limitation: the dead slot lasts one clock even if no word is valid in it
    always_comb begin
        next_r           = r;
        next_r.reg_we    = 1'b0;
        next_r.acc_we    = 1'b0;
        next_r.st        = SJX_S_RUN;
        if (instr_valid) begin
            next_r.pc = r.pc + 13'h0001;
        end
        if (live) begin
            unique case (kind)
                // Both skips share one write path; only the operator differs
                SJX_K_DEC, SJX_K_INC: begin
                    if (dest_reg) begin
                        next_r.reg_we    = 1'b1;
                        next_r.reg_waddr = reg_addr;
                        next_r.reg_wdata = result;
                    end else begin
                        next_r.acc_we    = 1'b1;
                        next_r.acc_wdata = result;
                    end
                    if (zero) begin
                        next_r.st = SJX_S_BUBBLE;
                    end
                end
                SJX_K_JUMP: begin
                    // The increment above is overridden; flush drops the sequential word
                    next_r.pc = {pc_high_latch[SJX_LATCH_HI:SJX_LATCH_LO], literal};
                    next_r.st = SJX_S_BUBBLE;
                end
                SJX_K_OTHER: begin
                end
            endcase
        end
    end

    // State register; synchronous reset
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '{st: SJX_S_RUN, pc: SJX_PC_RESET, reg_we: 1'b0, reg_waddr: 7'h00,
                   reg_wdata: 8'h00, acc_we: 1'b0, acc_wdata: 8'h00};
        end else begin
            r <= next_r;
        end
    end

    // Outputs; flush is combinational so the prefetcher can drop this cycle's fetch
    assign reg_raddr  = reg_addr;
    assign reg_we     = r.reg_we;
    assign reg_waddr  = r.reg_waddr;
    assign reg_wdata  = r.reg_wdata;
    assign acc_we     = r.acc_we;
    assign acc_wdata  = r.acc_wdata;
    assign status_we  = 1'b0;
    assign pc         = r.pc;
    // Other words give a zero result too, so the skip class gates the zero test
    assign flush      = live && ((kind == SJX_K_JUMP) || (sjx_is_skip(kind) && zero));
    assign bubble     = (r.st == SJX_S_BUBBLE);
    assign other_exec = live && (kind == SJX_K_OTHER);

    // Checks
    // Steps of a taken skip, an untaken skip and a jump, then of the slot after
    sequence s_skip_taken;
        live && sjx_is_skip(kind) && zero;
    endsequence
    sequence s_skip_kept;
        live && sjx_is_skip(kind) && !zero;
    endsequence
    sequence s_jump;
        live && kind == SJX_K_JUMP;
    endsequence
    sequence s_dead_slot;
        bubble && !flush && !other_exec;
    endsequence
    sequence s_no_write;
        !reg_we && !acc_we;
    endsequence

    // Skip timing: a taken skip spends one dead slot, an untaken one none
    a_skip_bubble: assert property (@(posedge clk) disable iff (reset)
        s_skip_taken |=> s_dead_slot ##1 s_no_write) else $error("skip bubble missing");
    a_skip_kept: assert property (@(posedge clk) disable iff (reset)
        s_skip_kept |-> !flush ##1 !bubble) else $error("untaken skip stalled");
    a_bubble_once: assert property (@(posedge clk) disable iff (reset)
        bubble |=> !bubble) else $error("dead slot too long");
    // The dead slot's word must leave no write and no hand-off to the core
    a_dead_slot: assert property (@(posedge clk) disable iff (reset)
        bubble |-> s_dead_slot ##1 s_no_write) else $error("dead slot acted");

    // Jump: target, forced dead slot, decode
    a_jump_target: assert property (@(posedge clk) disable iff (reset)
        s_jump |=> pc == {$past(pc_high_latch[4:3]), $past(literal)}) else $error("bad jump target");
    a_jump_low: assert property (@(posedge clk) disable iff (reset)
        s_jump |=> pc[SJX_LIT_MSB:0] == $past(literal)) else $error("bad jump literal");
    a_jump_flush: assert property (@(posedge clk) disable iff (reset)
        s_jump |-> flush ##1 bubble) else $error("jump not two cycles");
    a_jump_decode: assert property (@(posedge clk) disable iff (reset)
        instr[13:12] == SJX_OP_JUMP |-> kind == SJX_K_JUMP) else $error("jump decode");

    // Flags are never written, whatever the result
    a_no_status: assert property (@(posedge clk) disable iff (reset)
        !status_we) else $error("status written");

    // Arithmetic and destination of both skips
    a_dec_value: assert property (@(posedge clk) disable iff (reset)
        live && kind == SJX_K_DEC && dest_reg |=> reg_we && reg_wdata == $past(reg_rdata) - 8'h01)
        else $error("decrement wrong");
    a_dec_to_acc: assert property (@(posedge clk) disable iff (reset)
        live && kind == SJX_K_DEC && !dest_reg |=> acc_we && !reg_we && acc_wdata == $past(reg_rdata) - SJX_ONE)
        else $error("decrement target wrong");
    a_inc_value: assert property (@(posedge clk) disable iff (reset)
        live && kind == SJX_K_INC && !dest_reg |=> acc_we && acc_wdata == $past(reg_rdata) + 8'h01)
        else $error("increment wrong");
    a_inc_to_reg: assert property (@(posedge clk) disable iff (reset)
        live && kind == SJX_K_INC && dest_reg |=> reg_we && !acc_we && reg_waddr == $past(reg_addr)
            && reg_wdata == $past(reg_rdata) + SJX_ONE)
        else $error("increment target wrong");

    // Counter advance and opcode decode
    a_no_skip_run: assert property (@(posedge clk) disable iff (reset)
        live && kind != SJX_K_JUMP && !flush && instr_valid |=> !bubble && pc == $past(pc) + 13'h0001)
        else $error("no-skip path wrong");
    a_dec_decode: assert property (@(posedge clk) disable iff (reset)
        instr[13:8] == 6'h0b |-> kind == SJX_K_DEC) else $error("dec decode");
    a_inc_decode: assert property (@(posedge clk) disable iff (reset)
        instr[13:8] == 6'h0f |-> kind == SJX_K_INC) else $error("inc decode");

    // Reset leaves the slot idle at address zero, with no dead slot pending
    a_reset_clear: assert property (@(posedge clk)
        reset |=> pc == SJX_PC_RESET && !bubble && !reg_we && !acc_we) else $error("reset state wrong");
endmodule : sjx_exec

// file: bench/test_skip_and_jump_instr_exec.sv
// Bench for the skip and jump execution slot
module test_skip_and_jump_instr_exec import sjx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic fl, oth, bub, rwe, awe;
        logic [7:0] wd;
        logic [6:0] wa, ra;
        logic [12:0] pc;
    } sjx_exp_t;
    logic        clk, reset, instr_valid, reg_we, acc_we, status_we, flush, bubble, other_exec;
    logic [13:0] instr, w;
    logic [7:0]  reg_rdata, pc_high_latch, reg_wdata, acc_wdata, rd;
    logic [6:0]  reg_raddr, reg_waddr;
    logic [12:0] pc, pc_m;
    logic        bub_m;
    logic        cur_ok = 1'b0;
    sjx_exp_t    cur;
    sjx_exp_t    exp_q[$];
    int          err_total = 0;
    int          check_count = 0;
    int          cycles = 0;

    sjx_exec DUT (.clk(clk), .reset(reset), .instr(instr), .instr_valid(instr_valid),
        .reg_rdata(reg_rdata), .pc_high_latch(pc_high_latch), .reg_raddr(reg_raddr),
        .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .acc_we(acc_we),
        .acc_wdata(acc_wdata), .status_we(status_we), .pc(pc), .flush(flush),
        .bubble(bubble), .other_exec(other_exec));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk_f(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_f

    task automatic chk_v(input string nm, input logic [12:0] e, input logic [12:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_v

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // Drive one slot and note what the slot must produce; a bubble slot ignores its word
    task automatic issue(input logic [13:0] iw, input logic [7:0] ird, input logic [7:0] lt);
        sjx_exp_t e;
        logic [7:0] res;
        e = '0;
        e.ra = iw[6:0];
        res = (iw[13:8] == SJX_OP_INCSKIP) ? ird + 8'h01 : ird - 8'h01;
        @(posedge clk);
        instr <= iw;
        instr_valid <= 1'b1;
        reg_rdata <= ird;
        pc_high_latch <= lt;
        pc_m = pc_m + 13'h0001;
        if (!bub_m) begin
            if (iw[13:8] == SJX_OP_DECSKIP || iw[13:8] == SJX_OP_INCSKIP) begin
                e.fl = (res == 8'h00);
                e.rwe = iw[7];
                e.awe = !iw[7];
                e.wd = res;
                e.wa = iw[6:0];
            end else if (iw[13:12] == SJX_OP_JUMP) begin
                e.fl = 1'b1;
                pc_m = {lt[4:3], iw[10:0]};
            end else begin
                e.oth = 1'b1;
            end
        end
        e.bub = e.fl;
        bub_m = e.fl;
        e.pc = pc_m;
        exp_q.push_back(e);
    endtask : issue

    // Close a test; a pending bubble slot gets a word first, then the slot idles
    task automatic done(input string nm);
        if (bub_m)
            issue(14'h0000, 8'h00, 8'h00);
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (2) @(posedge clk);
        $display("Test %s done", nm);
    endtask : done

    // Mid-cycle watcher: registered results of the previous slot, then flush of this one
    always @(negedge clk) begin
        if (cur_ok) begin
            chk_f("reg_we", cur.rwe, reg_we);
            chk_f("acc_we", cur.awe, acc_we);
            if (cur.rwe) chk_v("reg_wdata", {5'h00, cur.wd}, {5'h00, reg_wdata});
            if (cur.rwe) chk_v("reg_waddr", {6'h00, cur.wa}, {6'h00, reg_waddr});
            if (cur.awe) chk_v("acc_wdata", {5'h00, cur.wd}, {5'h00, acc_wdata});
            chk_v("pc", cur.pc, pc);
            chk_f("bubble", cur.bub, bubble);
        end
        chk_f("status_we", 1'b0, status_we);
        cur_ok = (exp_q.size() > 0);
        if (cur_ok) begin
            cur = exp_q.pop_front();
            chk_f("flush", cur.fl, flush);
            chk_f("other_exec", cur.oth, other_exec);
            chk_v("reg_raddr", {6'h00, cur.ra}, {6'h00, reg_raddr});
        end
    end

    // Hang guard, far above the roughly 90 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // Main sequence
    initial begin
        instr = 14'h0000;
        instr_valid = 1'b0;
        reg_rdata = 8'h00;
        pc_high_latch = 8'h00;
        reset = 1'b1;
        bub_m = 1'b0;
        pc_m = SJX_PC_RESET;
        void'($urandom(85));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk_v("pc", SJX_PC_RESET, pc);
        issue({SJX_OP_DECSKIP, 1'b1, 7'h7f}, 8'h01, 8'h00);
        issue({SJX_OP_DECSKIP, 1'b1, 7'h05}, 8'h01, 8'h00);
        issue({SJX_OP_DECSKIP, 1'b0, 7'h00}, 8'h00, 8'h00);
        issue({SJX_OP_DECSKIP, 1'b1, 7'h11}, 8'h05, 8'h00);
        done("decrement skip");
        issue({SJX_OP_INCSKIP, 1'b0, 7'h40}, 8'hff, 8'h00);
        issue({SJX_OP_INCSKIP, 1'b0, 7'h41}, 8'hff, 8'h00);
        issue({SJX_OP_INCSKIP, 1'b1, 7'h42}, 8'h7f, 8'h00);
        done("increment skip");
        issue({SJX_OP_JUMP, 1'b1, 11'h7ff}, 8'h00, 8'h18);
        issue({SJX_OP_JUMP, 12'h000}, 8'h00, 8'he7);
        issue({SJX_OP_JUMP, 1'b0, 11'h123}, 8'h00, 8'he7);
        issue({6'h03, 1'b1, 7'h10}, 8'h01, 8'h00);
        issue({6'h0a, 1'b0, 7'h10}, 8'hff, 8'h00);
        done("jump and others");
        // Random words biased towards the three handled opcodes and zero results
        repeat (60) begin
            w = 14'($urandom);
            case ($urandom_range(0, 3))
                0: w[13:8] = SJX_OP_DECSKIP;
                1: w[13:8] = SJX_OP_INCSKIP;
                2: w[13:12] = SJX_OP_JUMP;
                default: ;
            endcase
            rd = 8'($urandom);
            if ($urandom_range(0, 1) == 1) rd = w[10] ? 8'hff : 8'h01;
            issue(w, rd, 8'($urandom));
        end
        done("random");
        tally_and_finish();
    end
endmodule : test_skip_and_jump_instr_exec
